//--- hw/word_link_if.sv
// three-wire write-only link between host and generator port
// assumes the two ends need not share a clock; pins are plain wires
`timescale 1ns/1ns
interface word_link_if;
	logic serial_clk;
	logic frame_select_n;
	logic serial_data_in;
	modport host (output serial_clk, output frame_select_n, output serial_data_in);
	modport dev (input serial_clk, input frame_select_n, input serial_data_in);
endinterface

//--- hw/word_loader_consts.svh
// constants shared by both ends of the three-wire serial word link
// assumes inclusion by bare name from the package and both end modules
`ifndef WORD_LOADER_CONSTS_SVH
`define WORD_LOADER_CONSTS_SVH
`define WL_WORD_BITS 16
`define WL_BYTE_BITS 8
`define WL_CNT_W 5
`define WL_CNT_ZERO 5'h00
`define WL_CNT_ONE 5'h01
`define WL_CNT_FULL 5'h10
`define WL_CNT_BYTE 5'h08
`define WL_CTRL_HI 15
`define WL_CTRL_LO 12
`define WL_ADDR_HI 11
`define WL_ADDR_LO 8
`define WL_DATA_HI 7
`define WL_DATA_LO 0
`define WL_DIV_HALF 4'h3
`define WL_DIV_W 4
`define WL_GAP_HALVES 4'h2
`define WL_SYNC_RST 2'h3
`endif

//--- hw/word_loader_dev.sv
// device end: assembles 16-bit words and splits them into fields
// assumes link pins are asynchronous to sys_clk; serial clock well below sys_clk/4
`timescale 1ns/1ns
`include "word_loader_consts.svh"
module word_loader_dev
	import word_loader_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// link
	word_link_if.dev link,
	// decoded word
	output logic word_valid,
	output word_t word_out,
	output logic [3:0] ctrl_code,
	output logic [3:0] dest_addr,
	output byte_t data_byte
);
	logic [1:0] clk_s_r, fs_s_r;
	logic [1:0] dat_s_r;
	logic clk_d_r;
	logic [`WL_CNT_W-1:0] cnt_r;
	word_t sh_r;
	logic valid_r;
	word_t word_r;

	wire clk_now = clk_s_r[1];
	wire frame_on = !fs_s_r[1];
	wire fall = clk_d_r && !clk_now;
	wire take = fall && frame_on && (cnt_r != `WL_CNT_FULL);
	wire word_t sh_nxt = {sh_r[`WL_WORD_BITS-2:0], dat_s_r[1]};
	wire done = take && (cnt_r == `WL_CNT_FULL - `WL_CNT_ONE);

	assign word_valid = valid_r;
	assign word_out = word_r;
	assign ctrl_code = word_r[`WL_CTRL_HI:`WL_CTRL_LO];
	assign dest_addr = word_r[`WL_ADDR_HI:`WL_ADDR_LO];
	assign data_byte = word_r[`WL_DATA_HI:`WL_DATA_LO];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			clk_s_r <= `WL_SYNC_RST;
			fs_s_r <= `WL_SYNC_RST;
			dat_s_r <= 2'h0;
			clk_d_r <= 1'b1;
		end else begin
			clk_s_r <= {clk_s_r[0], link.serial_clk};
			fs_s_r <= {fs_s_r[0], link.frame_select_n};
			dat_s_r <= {dat_s_r[0], link.serial_data_in};
			clk_d_r <= clk_now;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= `WL_CNT_ZERO;
			sh_r <= '0;
			valid_r <= 1'b0;
			word_r <= '0;
		end else begin
			valid_r <= done;
			if (!frame_on) begin
				cnt_r <= `WL_CNT_ZERO;
			end else if (take) begin
				cnt_r <= cnt_r + `WL_CNT_ONE;
				sh_r <= sh_nxt;
			end
			if (done) begin
				word_r <= sh_nxt;
			end
		end
	end
endmodule

//--- hw/word_loader_host.sv
// host end: sends one 16-bit word per request in one frame, unbroken or as two bytes with a clock gap
// assumes a single user on sys_clk; makes the serial clock by dividing sys_clk
`timescale 1ns/1ns
`include "word_loader_consts.svh"
module word_loader_host
	import word_loader_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// user request
	input wire logic send_valid,
	output logic send_ready,
	input word_t send_word,
	input wire logic byte_mode,
	input wire logic lsb_first_bytes,
	// link
	word_link_if.host link
);
	host_state_t state_r, state_nxt;
	logic [`WL_DIV_W-1:0] div_r;
	logic [`WL_CNT_W-1:0] cnt_r;
	logic sclk_r;
	logic fsn_r;
	logic sdo_r;
	word_t sh_r;
	logic byte_r;

	// reverse bits of a byte; load_word applies it twice, so lsb_first_bytes still sends each byte msb first
	function automatic byte_t rev_byte(input byte_t b);
		byte_t r;
		r = '0;
		for (int i = 0; i < `WL_BYTE_BITS; i++) begin
			r[i] = b[`WL_BYTE_BITS-1-i];
		end
		return r;
	endfunction

	wire half_tick = (div_r == `WL_DIV_HALF);
	wire word_t load_word = lsb_first_bytes ?
		{rev_byte(rev_byte(send_word[`WL_WORD_BITS-1:`WL_BYTE_BITS])),
		rev_byte(rev_byte(send_word[`WL_BYTE_BITS-1:0]))} : send_word;
	wire fall_edge = half_tick && sclk_r && (state_r == H_SHIFT);
	wire rise_edge = half_tick && !sclk_r && (state_r == H_SHIFT);
	wire last_bit = (cnt_r == `WL_CNT_FULL);
	wire byte_done = byte_r && (cnt_r == `WL_CNT_BYTE);

	assign send_ready = (state_r == H_IDLE);
	assign link.serial_clk = sclk_r;
	assign link.frame_select_n = fsn_r;
	assign link.serial_data_in = sdo_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			H_IDLE: if (send_valid) state_nxt = H_LEAD;
			H_LEAD: if (half_tick) state_nxt = H_SHIFT;
			H_SHIFT: begin
				if (rise_edge && last_bit) state_nxt = H_TAIL;
				else if (rise_edge && byte_done) state_nxt = H_GAP;
			end
			H_GAP: if (half_tick) state_nxt = H_SHIFT;
			H_TAIL: if (half_tick) state_nxt = H_IDLE;
			default: state_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= H_IDLE;
			div_r <= '0;
		end else begin
			state_r <= state_nxt;
			div_r <= (half_tick || state_r == H_IDLE) ? '0 : div_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_r <= 1'b1;
			fsn_r <= 1'b1;
			sdo_r <= 1'b0;
			sh_r <= '0;
			cnt_r <= `WL_CNT_ZERO;
			byte_r <= 1'b0;
		end else if (state_r == H_IDLE && send_valid) begin
			byte_r <= byte_mode;
			cnt_r <= `WL_CNT_ZERO;
			fsn_r <= 1'b0;
			sdo_r <= load_word[`WL_WORD_BITS-1];
			sh_r <= {load_word[`WL_WORD_BITS-2:0], 1'b0};
		end else if (fall_edge) begin
			sclk_r <= 1'b0;
			cnt_r <= cnt_r + `WL_CNT_ONE;
		end else if (rise_edge) begin
			sclk_r <= 1'b1;
			// the rise closing the first byte already presents the next bit, so data holds across the gap
			if (!last_bit) begin
				sdo_r <= sh_r[`WL_WORD_BITS-1];
				sh_r <= {sh_r[`WL_WORD_BITS-2:0], 1'b0};
			end
		end else if (state_r == H_GAP && half_tick) begin
			byte_r <= 1'b0;
		end else if (state_r == H_TAIL && half_tick) begin
			fsn_r <= 1'b1;
		end
	end
endmodule

//--- hw/word_loader_pkg.sv
// types for the serial word link
// assumes the constants header is on the include path
`include "word_loader_consts.svh"
package word_loader_pkg;
	typedef logic [`WL_WORD_BITS-1:0] word_t;
	typedef logic [`WL_BYTE_BITS-1:0] byte_t;
	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_LEAD = 5'h02,
		H_SHIFT = 5'h04,
		H_GAP = 5'h08,
		H_TAIL = 5'h10
	} host_state_t;
endpackage

//--- testbench/serial_word_loader_chk.sv
// checker: wire-level relations on the three-wire link
// assumes instantiation beside the host-to-device interface
`timescale 1ns/1ns
module serial_word_loader_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// link
	input wire logic serial_clk,
	input wire logic frame_select_n,
	input wire logic serial_data_in
);
	logic [4:0] fall_cnt_r;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// falling clock edges seen inside the current frame
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			fall_cnt_r <= 5'h00;
		else if (frame_select_n)
			fall_cnt_r <= 5'h00;
		else if ($fell(serial_clk))
			fall_cnt_r <= fall_cnt_r + 5'h01;
	end
	data_on_rise_a: assert property (!frame_select_n && $changed(serial_data_in) |->
		$rose(serial_clk) || $fell(frame_select_n)) else $error("data moved off a rising edge");
	clk_idle_a: assert property (frame_select_n |-> serial_clk) else $error("clock low outside frame");
	fall_in_frame_a: assert property ($fell(serial_clk) |-> !frame_select_n) else $error("edge outside frame");
	half_period_a: assert property ($changed(serial_clk) |=> $stable(serial_clk)[*3])
		else $error("clock half period short");
	frame_lead_a: assert property ($fell(frame_select_n) |-> serial_clk[*4]) else $error("no lead time");
	frame_len_a: assert property ($rose(frame_select_n) |-> fall_cnt_r == 5'h10)
		else $error("frame not sixteen bits");
	frame_max_a: assert property (fall_cnt_r <= 5'h10) else $error("frame too long");
	frame_release_a: assert property ($rose(frame_select_n) |-> $past(serial_clk, 4) && serial_clk)
		else $error("frame released early");
endmodule

//--- testbench/serial_word_loader_tb_top.sv
// bench: host and device back to back, plus a second device driven by the bench
// assumes 50 MHz sys_clk and the shared link interface
`timescale 1ns/1ns
module serial_word_loader_tb_top;
	import word_loader_pkg::*;
	logic sys_clk = 0, nrst = 0, send_valid = 0, byte_mode = 0, lsb_first_bytes = 0;
	logic send_ready, word_valid, v2;
	word_t send_word = 16'h0000, word_out, w2;
	logic [3:0] ctrl_code, dest_addr;
	byte_t data_byte;
	int n_mismatch = 0, compares = 0, cyc = 0, nv2 = 0;
	word_link_if link();
	word_link_if link2();
	always #10 sys_clk = ~sys_clk;
	word_loader_host word_loader_host_i(.sys_clk(sys_clk), .nrst(nrst), .send_valid(send_valid),
		.send_ready(send_ready), .send_word(send_word), .byte_mode(byte_mode),
		.lsb_first_bytes(lsb_first_bytes), .link(link));
	word_loader_dev word_loader_dev_i(.sys_clk(sys_clk), .nrst(nrst), .link(link), .word_valid(word_valid),
		.word_out(word_out), .ctrl_code(ctrl_code), .dest_addr(dest_addr), .data_byte(data_byte));
	word_loader_dev word_loader_dev_b_i(.sys_clk(sys_clk), .nrst(nrst), .link(link2), .word_valid(v2),
		.word_out(w2), .ctrl_code(), .dest_addr(), .data_byte());
	serial_word_loader_chk serial_word_loader_chk_i(.sys_clk(sys_clk), .nrst(nrst), .serial_clk(link.serial_clk),
		.frame_select_n(link.frame_select_n), .serial_data_in(link.serial_data_in));
	always @(posedge sys_clk) begin
		cyc++;
		if (v2 === 1'b1)
			nv2++;
		if (cyc == 8000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic chk(input string s, input word_t e, input word_t g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	task automatic send(input word_t w, input logic bm, input logic lf);
		int i;
		while (send_ready !== 1'b1) @(negedge sys_clk);
		send_word = w;
		byte_mode = bm;
		lsb_first_bytes = lf;
		send_valid = 1;
		@(negedge sys_clk);
		send_valid = 0;
		chk("send_ready", 0, send_ready);
		for (i = 0; i < 400 && word_valid !== 1'b1; i++) @(negedge sys_clk);
		chk("word_out", w, word_out);
		chk("ctrl_code", w[15:12], ctrl_code);
		chk("dest_addr", w[11:8], dest_addr);
		chk("data_byte", w[7:0], data_byte);
		@(negedge sys_clk);
		chk("word_valid", 0, word_valid);
	endtask
	// bit-banged frame of n bits on the second link, msb first
	task automatic bang(input word_t w, input int n);
		link2.frame_select_n = 0;
		for (int i = 0; i < n; i++) begin
			link2.serial_data_in = w[15-i];
			repeat (4) @(negedge sys_clk);
			link2.serial_clk = 0;
			repeat (4) @(negedge sys_clk);
			link2.serial_clk = 1;
		end
		repeat (4) @(negedge sys_clk);
		link2.frame_select_n = 1;
		link2.serial_data_in = ~link2.serial_data_in;
		repeat (10) @(negedge sys_clk);
	endtask
	task automatic t_words();
		word_t tab[4] = '{16'hA5C3, 16'h3C5A, 16'h8001, 16'h7FFE};
		for (int k = 0; k < 4; k++)
			send(tab[k], k[0], k[1]);
		$display("words test done");
	endtask
	task automatic t_partial();
		bang(16'hFFFF, 8);
		chk("partial words", 0, nv2);
		bang(16'h1234, 16);
		chk("full words", 1, nv2);
		chk("word after partial", 16'h1234, w2);
		$display("partial test done");
	endtask
	task automatic stop_test();
		$display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		link2.serial_clk = 1;
		link2.frame_select_n = 1;
		link2.serial_data_in = 0;
		repeat (20) @(negedge sys_clk);
		nrst = 1;
		t_words();
		t_partial();
		stop_test();
	end
endmodule
